// ### sbs_defs.svh
// sbs_defs.svh: constants for the synchronous burst sram core
// assumes inclusion by bare name from design files
`ifndef SBS_DEFS_SVH
`define SBS_DEFS_SVH
`define SBS_LANES       8
`define SBS_LANE_W      9
`define SBS_ADDR_W      18
`define SBS_BURST_LEN   4
`define SBS_WR_LAT_PIPE 2
`define SBS_WR_LAT_FLOW 1
`define SBS_FIFO_DEPTH  4
`endif

// ### sbs_pkg.sv
// sbs_pkg.sv: types shared by the burst sram core
// assumes sbs_defs.svh for widths
`default_nettype none
`include "sbs_defs.svh"
package sbs_pkg;
	typedef enum logic [1:0] {
		SBS_ACTIVE = 2'b00,
		SBS_SUSPEND = 2'b01,
		SBS_SLEEP = 2'b11
	} sbs_state_t;
	typedef logic [`SBS_LANES*`SBS_LANE_W-1:0] sbs_word_t;
endpackage : sbs_pkg
`default_nettype wire

// ### sbs_fifo.sv
// sbs_fifo.sv: small valid/ready fifo for read data
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module sbs_fifo #(
	parameter int WIDTH = 72,
	parameter int DEPTH = 4
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             ce_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wp_ff, nxt_wp, rp_ff, nxt_rp;
	logic [AW:0]      cnt_ff, nxt_cnt;
	logic             push, pop;

	// honest flags straight from the count
	assign in_ready_o  = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_ff != '0);
	assign out_data_o  = mem_ff[rp_ff];
	assign push = in_valid_i && in_ready_o;
	assign pop  = out_valid_o && out_ready_i;

	// pointer and count next values
	always_comb begin
		nxt_wp  = push ? ((wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1) : wp_ff;
		nxt_rp  = pop ? ((rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1) : rp_ff;
		nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
	end

	// storage frozen along with the rest when clock enable is low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wp_ff  <= '0;
			rp_ff  <= '0;
			cnt_ff <= '0;
		end else if (ce_i) begin
			wp_ff  <= nxt_wp;
			rp_ff  <= nxt_rp;
			cnt_ff <= nxt_cnt;
			if (push) mem_ff[wp_ff] <= in_data_i;
		end
	end
endmodule : sbs_fifo
`default_nettype wire

// ### sbs_core.sv
// sbs_core.sv: synchronous burst sram core, pipelined or flow-through
// assumes inputs synchronous to clk_i; data pin split into in/out/oe
`timescale 1ns/1ps
`default_nettype none
`include "sbs_defs.svh"
module sbs_core #(
	parameter int ADDR_W = `SBS_ADDR_W,
	parameter int LANES  = `SBS_LANES,
	parameter int LANE_W = `SBS_LANE_W,
	parameter int DEPTH  = 256
) (
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	input  wire logic                    clk_gate_n_i,
	input  wire logic                    chip_select_first_n_i,
	input  wire logic                    chip_select_second_i,
	input  wire logic                    chip_select_third_n_i,
	input  wire logic                    advance_load_i,
	input  wire logic                    write_n_i,
	input  wire logic [LANES-1:0]        byte_write_n_i,
	input  wire logic [ADDR_W-1:0]       addr_i,
	input  wire logic [LANES*LANE_W-1:0] dq_i,
	output logic      [LANES*LANE_W-1:0] dq_o,
	output logic                         dq_oe_o,
	input  wire logic                    output_enable_n_i,
	input  wire logic                    sleep_request_i,
	input  wire logic                    flow_through_select_n_i,
	input  wire logic                    burst_order_select_n_i,
	input  wire logic                    parity_odd_i,
	output logic      [LANES-1:0]        parity_error_o,
	output logic                         sleeping_o,
	output logic      [LANES*LANE_W-1:0] rd_data_o,
	output logic                         rd_valid_o,
	input  wire logic                    rd_ready_i,
	output logic                         rd_stall_o
);
	localparam int W  = LANES*LANE_W;
	localparam int MW = $clog2(DEPTH);

	logic [W-1:0] mem_ff [DEPTH];
	sbs_pkg::sbs_state_t st_ff, nxt_st;
	logic [ADDR_W-1:0]   base_ff, nxt_base;
	logic [1:0]          beat_ff, nxt_beat;
	logic                wr_burst_ff, nxt_wr_burst;
	logic                act_burst_ff, nxt_act_burst;
	// write pipeline: stage 0 is the command edge, stage 1 the next
	logic [1:0]          wv_ff, nxt_wv;
	logic [ADDR_W-1:0]   wa_ff [2];
	logic [ADDR_W-1:0]   nxt_wa [2];
	logic [LANES-1:0]    wb_ff [2];
	logic [LANES-1:0]    nxt_wb [2];
	logic                rv_ff, nxt_rv;
	logic [ADDR_W-1:0]   ra_ff, nxt_ra;
	logic [W-1:0]        oreg_ff, nxt_oreg;
	logic                ov_ff, nxt_ov;
	logic [LANES-1:0]    perr_ff, nxt_perr;
	logic                selected, run, start, advance_load, wr_now, rd_now;
	logic [ADDR_W-1:0]   cur_addr;
	logic                pipe_mode, wdone;
	logic [ADDR_W-1:0]   wdone_a;
	logic [LANES-1:0]    wdone_b;
	logic [W-1:0]        flow_data, merged;
	logic                fifo_ready;

	assign pipe_mode = flow_through_select_n_i; // low selects flow-through
	assign selected  = !chip_select_first_n_i && chip_select_second_i
	                   && !chip_select_third_n_i;
	assign run = (st_ff == sbs_pkg::SBS_ACTIVE) && !clk_gate_n_i && !sleep_request_i;
	assign start = run && selected && !advance_load_i;
	assign advance_load   = run && advance_load_i && act_burst_ff;

	// burst address: linear add or xor interleave on the two lsbs
	always_comb begin
		cur_addr = base_ff;
		if (burst_order_select_n_i)
			cur_addr[1:0] = base_ff[1:0] ^ beat_ff;
		else
			cur_addr[1:0] = base_ff[1:0] + beat_ff;
	end

	assign wr_now = start ? !write_n_i : (advance_load && wr_burst_ff);
	assign rd_now = start ? write_n_i : (advance_load && !wr_burst_ff);

	// write completes at the edge where its late data is on the pins
	assign wdone   = pipe_mode ? wv_ff[1] : wv_ff[0];
	assign wdone_a = pipe_mode ? wa_ff[1] : wa_ff[0];
	assign wdone_b = pipe_mode ? wb_ff[1] : wb_ff[0];

	// per-lane merge of late data into the stored word
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			logic par;
			assign par = ^dq_i[g*LANE_W +: LANE_W];
			assign merged[g*LANE_W +: LANE_W] = !wdone_b[g]
				? dq_i[g*LANE_W +: LANE_W]
				: mem_ff[wdone_a[MW-1:0]][g*LANE_W +: LANE_W];
			// even sense wants even ones over nine bits
			assign nxt_perr[g] = (run && wdone && !wdone_b[g]) ? (par != parity_odd_i)
				: perr_ff[g];
		end
	endgenerate

	// a write finishing this edge is visible to a read of the same word
	// compare on array bits only, so aliased high address bits still bypass
	assign flow_data = (wdone && (wdone_a[MW-1:0] == ra_ff[MW-1:0])) ? merged
	                   : mem_ff[ra_ff[MW-1:0]];

	// control, burst and pipeline next values
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			sbs_pkg::SBS_ACTIVE:  nxt_st = sleep_request_i ? sbs_pkg::SBS_SLEEP
			                             : (clk_gate_n_i ? sbs_pkg::SBS_SUSPEND
			                             : sbs_pkg::SBS_ACTIVE);
			sbs_pkg::SBS_SUSPEND: nxt_st = sleep_request_i ? sbs_pkg::SBS_SLEEP
			                             : (clk_gate_n_i ? sbs_pkg::SBS_SUSPEND
			                             : sbs_pkg::SBS_ACTIVE);
			sbs_pkg::SBS_SLEEP:   nxt_st = sleep_request_i ? sbs_pkg::SBS_SLEEP
			                             : sbs_pkg::SBS_SUSPEND;
			default:              nxt_st = sbs_pkg::SBS_SUSPEND;
		endcase
		nxt_base = base_ff;
		nxt_beat = beat_ff;
		nxt_wr_burst = wr_burst_ff;
		nxt_act_burst = act_burst_ff;
		nxt_wv = wv_ff;
		nxt_wa = wa_ff;
		nxt_wb = wb_ff;
		nxt_rv = rv_ff;
		nxt_ra = ra_ff;
		nxt_oreg = oreg_ff;
		nxt_ov = ov_ff;
		if (run) begin
			if (start) begin
				nxt_base = addr_i;
				nxt_beat = 2'h1;
				nxt_wr_burst = !write_n_i;
				nxt_act_burst = 1'b1;
			end else if (advance_load) begin
				nxt_beat = beat_ff + 2'h1;
			end else begin
				nxt_act_burst = 1'b0; // deselect ends the burst
			end
			// no turnaround gap: both pipes advance every run edge that the read fifo does not stall
			nxt_wv = {wv_ff[0], wr_now};
			nxt_wa[0] = start ? addr_i : cur_addr;
			nxt_wa[1] = wa_ff[0];
			nxt_wb[0] = byte_write_n_i; // strobes ride with every beat
			nxt_wb[1] = wb_ff[0];
			nxt_rv = rd_now;
			nxt_ra = start ? addr_i : cur_addr;
			nxt_oreg = flow_data;
			nxt_ov = rv_ff;
		end
	end

	// all state; the array write is the self-timed write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff <= sbs_pkg::SBS_ACTIVE;
			base_ff <= '0;
			beat_ff <= '0;
			wr_burst_ff <= 1'b0;
			act_burst_ff <= 1'b0;
			wv_ff <= '0;
			wa_ff <= '{default: '0};
			wb_ff <= '{default: '1};
			rv_ff <= 1'b0;
			ra_ff <= '0;
			oreg_ff <= '0;
			ov_ff <= 1'b0;
			perr_ff <= '0;
		end else if (!rd_stall_o || !run) begin
			st_ff <= nxt_st;
			base_ff <= nxt_base;
			beat_ff <= nxt_beat;
			wr_burst_ff <= nxt_wr_burst;
			act_burst_ff <= nxt_act_burst;
			wv_ff <= nxt_wv;
			wa_ff <= nxt_wa;
			wb_ff <= nxt_wb;
			rv_ff <= nxt_rv;
			ra_ff <= nxt_ra;
			oreg_ff <= nxt_oreg;
			ov_ff <= nxt_ov;
			perr_ff <= nxt_perr;
			if (run && wdone) mem_ff[wdone_a[MW-1:0]] <= merged;
		end
	end

	// pin data: register in pipeline, array path in flow-through
	assign dq_o = pipe_mode ? oreg_ff : mem_ff[ra_ff[MW-1:0]];
	assign dq_oe_o = !output_enable_n_i && !sleep_request_i
	                 && (pipe_mode ? ov_ff : rv_ff);
	assign parity_error_o = perr_ff;
	assign sleeping_o = (st_ff == sbs_pkg::SBS_SLEEP);
	// a full read fifo stalls the core rather than drop data
	assign rd_stall_o = !fifo_ready;

	sbs_fifo #(
		.WIDTH(W),
		.DEPTH(`SBS_FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.ce_i        (run),
		.in_data_i   (dq_o),
		.in_valid_i  (pipe_mode ? ov_ff : rv_ff),
		.in_ready_o  (fifo_ready),
		.out_data_o  (rd_data_o),
		.out_valid_o (rd_valid_o),
		.out_ready_i (rd_ready_i)
	);
endmodule : sbs_core
`default_nettype wire

// ### sbs_core_properties.sv
// sbs_core_properties.sv: port timing checks for the burst sram core
// assumes a bind into sbs_core with its default widths
`timescale 1ns/1ps
`default_nettype none
module sbs_core_properties (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        clk_gate_n_i,
	input wire logic        chip_select_first_n_i,
	input wire logic        chip_select_second_i,
	input wire logic        chip_select_third_n_i,
	input wire logic        advance_load_i,
	input wire logic        write_n_i,
	input wire logic [7:0]  byte_write_n_i,
	input wire logic [71:0] dq_i,
	input wire logic [71:0] dq_o,
	input wire logic        dq_oe_o,
	input wire logic        output_enable_n_i,
	input wire logic        sleep_request_i,
	input wire logic        flow_through_select_n_i,
	input wire logic        parity_odd_i,
	input wire logic [7:0]  parity_error_o,
	input wire logic        sleeping_o,
	input wire logic        rd_stall_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic sel, run, take, lerr, held_ff;
	// a gated edge leaves the core one edge in suspend, so the next command drops
	always_ff @(posedge clk_i) held_ff <= clk_gate_n_i;
	// a command counts only with every select on and the core free
	assign sel = !chip_select_first_n_i && chip_select_second_i && !chip_select_third_n_i;
	assign run = !clk_gate_n_i && !sleep_request_i && !rd_stall_o;
	assign take = sel && run && !sleeping_o && !advance_load_i && !held_ff;
	assign lerr = ^dq_i[8:0] ^ parity_odd_i;
	a_oe_kills_drive: assert property (output_enable_n_i |-> !dq_oe_o)
		else $error("drive on with output enable off");
	a_sleep_no_drive: assert property (sleep_request_i |-> !dq_oe_o)
		else $error("drive on during sleep request");
	a_sleep_entry: assert property (sleep_request_i [*3] |-> sleeping_o)
		else $error("no power-down after sleep request");
	a_pipe_read_lat: assert property (
		take && !$past(sleeping_o) && write_n_i && flow_through_select_n_i
		##1 (run && !output_enable_n_i) [*2] |-> dq_oe_o) else $error("pipelined read late");
	a_flow_read_lat: assert property (
		take && !$past(sleeping_o) && write_n_i && !flow_through_select_n_i
		##1 (run && !output_enable_n_i) |-> dq_oe_o) else $error("flow read late");
	a_pipe_write_quiet: assert property (
		take && !$past(sleeping_o) && !write_n_i && flow_through_select_n_i
		##1 run [*2] |-> !dq_oe_o) else $error("drive during write beat");
	a_deselect_idle: assert property (
		(!sel && !advance_load_i && !clk_gate_n_i) [*3] |-> !dq_oe_o)
		else $error("drive while deselected");
	a_parity_lane: assert property (
		take && !$past(sleeping_o) && !write_n_i && !byte_write_n_i[0]
		&& flow_through_select_n_i ##1 run [*2] |=> parity_error_o[0] == $past(lerr))
		else $error("lane parity flag wrong");
	a_gate_freeze: assert property (
		clk_gate_n_i && flow_through_select_n_i |=> $stable(parity_error_o) && $stable(dq_o))
		else $error("state moved with clock gated");
endmodule : sbs_core_properties
`default_nettype wire

// ### sbs_ctrl_model.sv
// sbs_ctrl_model.sv: controller side, supplies late write data
// assumes write commands flagged in the cycle the core takes them
`timescale 1ns/1ps
`default_nettype none
module sbs_ctrl_model (
	input  wire logic        clk_i,
	input  wire logic        flow_n_i,
	input  wire logic        wr_i,
	input  wire logic [71:0] wdata_i,
	output logic      [71:0] dq_o
);
	logic [72:0] st1, st2;
	// command stage, then one more for the pipelined beat; ignores gating
	always @(posedge clk_i) begin
		st1 <= {wr_i, wdata_i};
		st2 <= st1;
	end
	// no stale copy outside a beat, the lines flip instead
	always @(negedge clk_i) begin
		if (flow_n_i ? st2[72] : st1[72])
			dq_o <= flow_n_i ? st2[71:0] : st1[71:0];
		else
			dq_o <= ~dq_o;
	end
	initial dq_o = 72'h0;
endmodule : sbs_ctrl_model
`default_nettype wire

// ### sbs_core_tb.sv
// sbs_core_tb.sv: directed tests of the burst sram core
// assumes sbs_core, its fifo, the controller model and checker compiled
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module sbs_core_tb;
	logic        clk_i = 0, rst_i = 1, clk_gate_n_i = 0, chip_select_first_n_i = 0;
	logic        chip_select_second_i = 0, chip_select_third_n_i = 0, advance_load_i = 0;
	logic        write_n_i = 1, output_enable_n_i = 0, sleep_request_i = 0, parity_odd_i = 0;
	logic        flow_through_select_n_i = 1, burst_order_select_n_i = 1, rd_ready_i = 0;
	logic        dq_oe_o, sleeping_o, rd_valid_o, rd_stall_o, wr = 0;
	logic [7:0]  byte_write_n_i = 8'hff, parity_error_o;
	logic [17:0] addr_i = 18'h00000;
	logic [71:0] dq_i, dq_o, rd_data_o, wd = 72'h0;
	int          n_mismatch = 0, total_checks = 0, cyc = 0, m, k, a;
	sbs_core dut (.clk_i, .rst_i, .clk_gate_n_i, .chip_select_first_n_i, .chip_select_second_i,
		.chip_select_third_n_i, .advance_load_i, .write_n_i, .byte_write_n_i, .addr_i, .dq_i,
		.dq_o, .dq_oe_o, .output_enable_n_i, .sleep_request_i, .flow_through_select_n_i,
		.burst_order_select_n_i, .parity_odd_i, .parity_error_o, .sleeping_o, .rd_data_o,
		.rd_valid_o, .rd_ready_i, .rd_stall_o);
	sbs_ctrl_model u_ctrl (.clk_i, .flow_n_i(flow_through_select_n_i), .wr_i(wr), .wdata_i(wd),
		.dq_o(dq_i));
	always #25 clk_i = ~clk_i;
	// hang guard, far above the hundred or so cycles needed
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	// one command per cycle, set on the falling edge, taken on the rising
	task automatic cmd(input logic w, input logic advance_load, input logic [17:0] ad,
		input logic [71:0] d, input logic [7:0] be);
		chip_select_second_i = 1;
		write_n_i = w;
		advance_load_i = advance_load;
		addr_i = ad;
		wd = d;
		wr = !w;
		byte_write_n_i = be;
		@(negedge clk_i);
	endtask : cmd
	task automatic idle(input int n);
		chip_select_second_i = 0;
		advance_load_i = 0;
		wr = 0;
		rd_ready_i = 0;
		repeat (n) @(negedge clk_i);
	endtask : idle
	// ready stays up so every word is seen before the edge that pops it
	task automatic pop(input logic [71:0] e);
		int i;
		rd_ready_i = 1;
		for (i = 0; i < 20 && rd_valid_o !== 1'b1; i++)
			@(negedge clk_i);
		`CHK(rd_data_o, e)
		@(negedge clk_i);
	endtask : pop
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (5) @(negedge clk_i);
		rst_i = 0;
		// write, write, partial write, read back to back
		cmd(0, 0, 18'h00001, 72'h0123456789abcdef01, 8'h00);
		cmd(0, 0, 18'h00003, 72'h0, 8'h00);
		cmd(0, 0, 18'h00003, 72'h0000000000000003ff, 8'hfe);
		cmd(1, 0, 18'h00001, 72'h0, 8'hff);
		idle(1);
		cmd(1, 0, 18'h00003, 72'h0, 8'hff);
		idle(4);
		pop(72'h0123456789abcdef01);
		pop(72'h0000000000000001ff);
		`CHK(parity_error_o, 8'h01)
		// odd sense: lane 0 with nine ones passes, lane 1 with none fails
		parity_odd_i = 1;
		cmd(0, 0, 18'h00002, 72'h0000000000000001ff, 8'hfc);
		idle(3);
		`CHK(parity_error_o, 8'h02)
		parity_odd_i = 0;
		$display("test lanes done");
		// bursts: pipelined interleaved with drive off, flow linear with drive on
		for (m = 0; m < 2; m++) begin
			flow_through_select_n_i = (m == 0);
			burst_order_select_n_i = (m == 0);
			output_enable_n_i = (m == 0);
			idle(2);
			// one four-beat write burst from an aligned start fills 4..7 in either order
			for (k = 4; k < 8; k++)
				cmd(0, k != 4, 18'h00004, {8{9'h040 + 9'(k)}}, 8'h00);
			cmd(1, 0, 18'h00005, 72'h0, 8'hff);
			for (k = 1; k < 4; k++)
				cmd(1, 1, 18'h00005, 72'h0, 8'hff);
			`CHK(dq_oe_o, (m == 1))
			`CHK(dq_o, (m == 1) ? {8{9'h044}} : {8{9'h047}})
			idle(4);
			`CHK(rd_stall_o, 1'b1)
			for (k = 0; k < 4; k++) begin
				a = (m == 1) ? ((k + 1) & 3) : (k ^ 1);
				pop({8{9'h044 + 9'(a)}});
			end
			`CHK(rd_valid_o, 1'b0)
			$display("test burst %0d done", m);
		end
		// refused reads: one select off, clock gated, sleeping
		flow_through_select_n_i = 1;
		burst_order_select_n_i = 1;
		output_enable_n_i = 0;
		for (k = 0; k < 4; k++) begin
			chip_select_first_n_i = (k == 0);
			chip_select_third_n_i = (k == 1);
			clk_gate_n_i = (k == 2);
			sleep_request_i = (k == 3);
			cmd(1, 0, 18'h00001, 72'h0, 8'hff);
			idle(4);
			`CHK(rd_valid_o, 1'b0)
			`CHK(sleeping_o, (k == 3))
		end
		sleep_request_i = 0;
		idle(3);
		`CHK(sleeping_o, 1'b0)
		cmd(1, 0, 18'h00001, 72'h0, 8'hff);
		idle(4);
		pop(72'h0123456789abcdef01);
		$display("test refusal done");
		report_and_stop();
	end
endmodule : sbs_core_tb
bind sbs_core sbs_core_properties u_props (.clk_i, .rst_i, .clk_gate_n_i, .chip_select_first_n_i,
	.chip_select_second_i, .chip_select_third_n_i, .advance_load_i, .write_n_i, .byte_write_n_i,
	.dq_i, .dq_o, .dq_oe_o, .output_enable_n_i, .sleep_request_i, .flow_through_select_n_i,
	.parity_odd_i, .parity_error_o, .sleeping_o, .rd_stall_o);
`default_nettype wire
